/* hw/dbci_regs.sv */
`timescale 1ns/100ps
module dbci_regs (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Register bus
  input  wire dbci_pkg::dbci_wb_req_t wb_req,
  output dbci_pkg::dbci_wb_rsp_t      wb_rsp,
  // Engine side
  input  wire dbci_pkg::dbci_sts_t    sts,
  output dbci_pkg::dbci_cfg_t         cfg,
  output logic                        irq
);
  import dbci_pkg::*;

  logic           ack_ff, nxt_ack;
  logic [31:0]    rdat_ff, nxt_rdat;
  logic [8:0]     ctrl_ff, nxt_ctrl;
  logic [DW-1:0]  addr_ff, nxt_addr;
  logic [DW-1:0]  wdata_ff, nxt_wdata;
  logic [NEV-1:0] ist_ff, nxt_ist;
  logic [NEV-1:0] ien_ff, nxt_ien;
  logic           hit;
  logic           wr;
  logic [31:0]    m;
  logic [31:0]    d;

  // A write lands only on the edge where the master sees ack
  assign hit = wb_req.cyc & wb_req.stb;
  assign wr  = hit & wb_req.we & ack_ff;
  assign m   = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
  assign d   = wb_req.dat & m;

  // Next register values, read mux and sticky events
  always_comb begin
    nxt_ack   = hit & ~ack_ff;
    nxt_rdat  = 32'h0000_0000;
    nxt_ctrl  = ctrl_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_ist   = ist_ff;
    nxt_ien   = ien_ff;
    if (wr) begin
      case (wb_req.adr)
        ADR_CTRL:    nxt_ctrl = ((ctrl_ff & ~m[8:0]) | d[8:0]) & 9'h1FE;
        ADR_ADDR:    nxt_addr = (addr_ff & ~m[DW-1:0]) | d[DW-1:0];
        ADR_WDATA:   nxt_wdata = (wdata_ff & ~m[DW-1:0]) | d[DW-1:0];
        ADR_IRQ_CLR: nxt_ist = ist_ff & ~d[NEV-1:0];
        ADR_IRQ_EN:  nxt_ien = (ien_ff & ~m[NEV-1:0]) | d[NEV-1:0];
        default: ;
      endcase
    end
    // New event beats a clear in the same cycle
    nxt_ist = nxt_ist | sts.ev;
    if (hit & ~ack_ff & ~wb_req.we) begin
      case (wb_req.adr)
        ADR_CTRL:     nxt_rdat = 32'(ctrl_ff);
        ADR_ADDR:     nxt_rdat = 32'(addr_ff);
        ADR_WDATA:    nxt_rdat = 32'(wdata_ff);
        ADR_RDATA:    nxt_rdat = 32'(sts.rx);
        ADR_STATUS:   nxt_rdat = 32'({sts.ovf, sts.last, sts.cyc,
                                      sts.busy, sts.req});
        ADR_IRQ_STAT: nxt_rdat = 32'(ist_ff);
        ADR_IRQ_EN:   nxt_rdat = 32'(ien_ff);
        default:      nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdat_ff  <= 32'h0000_0000;
      ctrl_ff  <= CTRL_RST;
      addr_ff  <= ADDR_RST;
      wdata_ff <= WDATA_RST;
      ist_ff   <= '0;
      ien_ff   <= IRQ_EN_RST;
    end else begin
      ack_ff   <= nxt_ack;
      rdat_ff  <= nxt_rdat;
      ctrl_ff  <= nxt_ctrl;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      ist_ff   <= nxt_ist;
      ien_ff   <= nxt_ien;
    end
  end

  // Configuration view for the engine
  always_comb begin
    cfg.go     = wr & (wb_req.adr == ADR_CTRL) & d[CTRL_GO];
    cfg.enable = ctrl_ff[CTRL_EN];
    cfg.three  = ctrl_ff[CTRL_THREE];
    cfg.dir    = dbci_dir_t'(ctrl_ff[CTRL_DIR +: 2]);
    cfg.prio   = ctrl_ff[CTRL_PRIO +: 4];
    cfg.addr   = addr_ff;
    cfg.wdata  = wdata_ff;
  end

  assign wb_rsp.ack = ack_ff;
  assign wb_rsp.dat = rdat_ff;
  assign irq        = |(ist_ff & ien_ff);
endmodule : dbci_regs

/* hw/dbci_top.sv */
// Operation
// - Three-cycle mode runs count, address, then data cycles in that order
// - Own major state sequencer steps count, address and data cycles
// - Address cycle loads break address register from memory data lines
// - Priority is arbitrated again before every one of the three cycles
// - Strobe edge asserts break active and address disable if requested
// - Only in time state four drive own priority bit, examine others
// - Win at pulse four when all higher bits high; assert cycle lines
// - Break address on memory address lines within 50 ns of pulse four; here one 100 ns clock after pulse four rises
// - Next pulse one after winning asserts address and state load inhibit
// - Same pulse one sets add flop and drives transfer path lines
// - Control lines release in the order they were asserted
// - Input or add word held on data bus through time state two
// - Output word captured from memory data lines at pulse three
// - Overflow line is sampled at pulse three
// - Output drives direction low; add keeps it high, path select low
// - Request at pulse three strobe repeats; otherwise release everything
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module dbci_top (
  // Clock and reset
  input  wire logic                         REF_CLK,
  input  wire logic                         SYS_RST,
  // Register bus and interrupt
  input  wire dbci_pkg::dbci_wb_req_t       WB_REQ,
  output dbci_pkg::dbci_wb_rsp_t            WB_RSP,
  output logic                              IRQ,
  // Processor timing
  input  wire logic                         TIME_STATE_TWO,
  input  wire logic                         TIME_STATE_FOUR,
  input  wire logic                         PULSE_ONE,
  input  wire logic                         PULSE_THREE,
  input  wire logic                         PULSE_FOUR,
  input  wire logic                         SAMPLE_STROBE,
  // Memory side
  input  wire logic [dbci_pkg::DW-1:0]      MEMORY_DATA_LINES,
  input  wire logic                         OVERFLOW_N,
  output logic      [dbci_pkg::DW-1:0]      MEMORY_ADDRESS_LINES,
  output logic                              MEMORY_ADDRESS_OE,
  // Data bus
  input  wire logic [dbci_pkg::DW-1:0]      DATA_BUS_I,
  output logic      [dbci_pkg::DW-1:0]      DATA_BUS_O,
  output logic      [dbci_pkg::DW-1:0]      DATA_BUS_OE,
  // Break control lines
  output logic                              BREAK_ACTIVE_LINE_N,
  output logic                              PROCESSOR_ADDRESS_DISABLE_N,
  output logic                              BREAK_CYCLE_N,
  output logic                              STATE_INSTR_DISCONNECT_N,
  output logic                              ADDR_STATE_LOAD_INHIBIT_N,
  output logic                              TRANSFER_PATH_SELECT_N,
  output logic                              MEMORY_DATA_DIRECTION_N,
  output logic                              MEMORY_ADD_FLOP
);
  import dbci_pkg::*;
  localparam int MA_LAG = MA_SETTLE_CYC;
  dbci_cfg_t      cfg;
  dbci_sts_t      sts;
  logic [3:0]     pul, pul_ff, rise;
  logic           strobe_rise, tp1_rise, tp3_rise, tp4_rise;
  logic           req_ff, nxt_req;
  logic           nbr_ff, nxt_nbr;
  logic           mac_ff, nxt_mac;
  logic           malc_ff, nxt_malc;
  logic           adm_ff, nxt_adm;
  logic           padd_ff, nxt_padd;
  logic           pout_ff, nxt_pout;
  logic           last_ff, nxt_last;
  logic           ovf_ff, nxt_ovf;
  dbci_cyc_t      mstate_ff, nxt_mstate;
  dbci_cyc_t      kind_ff, nxt_kind;
  dbci_cyc_t      cur;
  dbci_dir_t      cur_dir;
  logic [DW-1:0]  ma_ff, nxt_ma;
  logic [DW-1:0]  break_address_register_ff, nxt_break_address_register;
  logic [DW-1:0]  tx_ff, nxt_tx;
  logic [DW-1:0]  rx_ff, nxt_rx;
  logic [NEV-1:0] ev_ff, nxt_ev;
  logic [DW-1:0]  onehot;
  logic [DW-1:0]  higher;
  logic [DW-1:0]  addr_sel;
  logic           win;
  logic           drive_word;
  // Register file and interrupt
  dbci_regs dbci_regs_inst (
    .clk    (REF_CLK),
    .rst    (SYS_RST),
    .wb_req (WB_REQ),
    .wb_rsp (WB_RSP),
    .sts    (sts),
    .cfg    (cfg),
    .irq    (IRQ)
  );
  // Leading edges of the timing pulses; pins are already synchronous
  assign pul         = {SAMPLE_STROBE, PULSE_FOUR, PULSE_THREE, PULSE_ONE};
  assign rise        = pul & ~pul_ff;
  assign strobe_rise = rise[3];
  assign tp4_rise    = rise[2];
  assign tp3_rise    = rise[1];
  assign tp1_rise    = rise[0];
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pul_ff <= 4'h0;
    end else begin
      pul_ff <= pul;
    end
  end
  // Priority network: bit 0 is the highest priority
  assign onehot = INC_WORD << cfg.prio;
  assign higher = onehot - INC_WORD;
  assign win    = &(DATA_BUS_I | ~higher);
  // Cycle kind: one-cycle mode always transfers data
  assign cur     = cfg.three ? mstate_ff : CYC_XFER;
  assign cur_dir = (cur == CYC_XFER) ? cfg.dir : DIR_ADD;
  // Address chosen for the cycle about to be won
  always_comb begin
    case (cur)
      CYC_WC:  addr_sel = cfg.addr;
      CYC_CA:  addr_sel = cfg.addr + INC_WORD;
      default: addr_sel = cfg.three ? break_address_register_ff : cfg.addr;
    endcase
  end
  // Break engine next state
  always_comb begin
    nxt_req    = req_ff;
    nxt_nbr    = nbr_ff;
    nxt_mac    = mac_ff;
    nxt_malc   = malc_ff;
    nxt_adm    = adm_ff;
    nxt_padd   = padd_ff;
    nxt_pout   = pout_ff;
    nxt_last   = last_ff;
    nxt_ovf    = ovf_ff;
    nxt_mstate = mstate_ff;
    nxt_kind   = kind_ff;
    nxt_ma     = ma_ff;
    nxt_break_address_register   = break_address_register_ff;
    nxt_tx     = tx_ff;
    nxt_rx     = rx_ff;
    nxt_ev     = '0;
    // Strobe latches the request; no request releases the first pair
    if (strobe_rise) begin
      nxt_nbr = req_ff & cfg.enable;
    end
    // Each cycle wins on its own arbitration, so others can cut in
    if (tp4_rise) begin
      nxt_mac = nbr_ff & win;
      if (nbr_ff & win) begin
        nxt_ma = addr_sel;
      end
    end
    // Pulse one follows the won cycle with inhibit and path
    if (tp1_rise) begin
      nxt_malc = mac_ff;
      nxt_adm  = mac_ff & (cur_dir == DIR_ADD);
      nxt_padd = mac_ff & (cur_dir == DIR_ADD);
      nxt_pout = mac_ff & (cur_dir == DIR_OUT);
      if (mac_ff) begin
        nxt_kind = cur;
        nxt_tx   = (cur == CYC_XFER) ? cfg.wdata : INC_WORD;
        if (cfg.three) begin
          case (mstate_ff)
            CYC_WC:  nxt_mstate = CYC_CA;
            CYC_CA:  nxt_mstate = CYC_XFER;
            default: nxt_mstate = CYC_WC;
          endcase
        end
        // Data cycle consumes the request unless the block goes on
        if ((cur == CYC_XFER) && (!cfg.three || last_ff)) begin
          nxt_req = 1'b0;
        end
      end
    end
    // Pulse three captures inside a running cycle
    if (tp3_rise && malc_ff) begin
      case (kind_ff)
        CYC_WC: begin
          nxt_last = ~OVERFLOW_N;
        end
        CYC_CA: begin
          nxt_break_address_register = MEMORY_DATA_LINES;
        end
        default: begin
          if (pout_ff) begin
            nxt_rx = MEMORY_DATA_LINES;
          end
          if (padd_ff) begin
            nxt_ovf = ~OVERFLOW_N;
          end
          nxt_ev[EV_WORD]  = 1'b1;
          nxt_ev[EV_BLOCK] = cfg.three & last_ff;
          nxt_ev[EV_OVF]   = padd_ff & ~OVERFLOW_N;
          nxt_last         = 1'b0;
        end
      endcase
    end
    // Software start beats a hardware clear in the same cycle
    if (cfg.go) begin
      nxt_req = 1'b1;
    end
    if (!cfg.three) begin
      nxt_mstate = CYC_WC;
    end
  end
  // Break engine registers
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      req_ff    <= 1'b0;
      nbr_ff    <= 1'b0;
      mac_ff    <= 1'b0;
      malc_ff   <= 1'b0;
      adm_ff    <= 1'b0;
      padd_ff   <= 1'b0;
      pout_ff   <= 1'b0;
      last_ff   <= 1'b0;
      ovf_ff    <= 1'b0;
      mstate_ff <= CYC_WC;
      kind_ff   <= CYC_WC;
      ma_ff     <= '0;
      break_address_register_ff   <= '0;
      tx_ff     <= '0;
      rx_ff     <= '0;
      ev_ff     <= '0;
    end else begin
      req_ff    <= nxt_req;
      nbr_ff    <= nxt_nbr;
      mac_ff    <= nxt_mac;
      malc_ff   <= nxt_malc;
      adm_ff    <= nxt_adm;
      padd_ff   <= nxt_padd;
      pout_ff   <= nxt_pout;
      last_ff   <= nxt_last;
      ovf_ff    <= nxt_ovf;
      mstate_ff <= nxt_mstate;
      kind_ff   <= nxt_kind;
      ma_ff     <= nxt_ma;
      break_address_register_ff   <= nxt_break_address_register;
      tx_ff     <= nxt_tx;
      rx_ff     <= nxt_rx;
      ev_ff     <= nxt_ev;
    end
  end
  // Data bus: priority bit in state four, word in state two
  assign drive_word = TIME_STATE_TWO & malc_ff & ~pout_ff;
  always_comb begin
    DATA_BUS_O  = 12'h000;
    DATA_BUS_OE = 12'h000;
    if (TIME_STATE_FOUR && nbr_ff) begin
      DATA_BUS_OE = onehot;
    end else if (drive_word) begin
      DATA_BUS_O  = tx_ff;
      DATA_BUS_OE = 12'hFFF;
    end
  end
  // Control lines straight from the flops; all active low except the add flop
  assign BREAK_ACTIVE_LINE_N         = ~nbr_ff;
  assign PROCESSOR_ADDRESS_DISABLE_N = ~nbr_ff;
  assign BREAK_CYCLE_N               = ~mac_ff;
  assign STATE_INSTR_DISCONNECT_N    = ~mac_ff;
  assign ADDR_STATE_LOAD_INHIBIT_N   = ~malc_ff;
  assign TRANSFER_PATH_SELECT_N      = ~padd_ff;
  assign MEMORY_DATA_DIRECTION_N     = ~pout_ff;
  assign MEMORY_ADD_FLOP             = adm_ff;
  // Address lines always carry the last won address; enabled only while the cycle is ours
  assign MEMORY_ADDRESS_LINES = ma_ff;
  assign MEMORY_ADDRESS_OE    = mac_ff;
  // Status toward software, in the order the status register packs it
  assign sts = '{req_ff, nbr_ff | mac_ff | malc_ff, mstate_ff,
                 last_ff, ovf_ff, rx_ff, ev_ff};
  // Checks on the break sequence
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_won;
    tp4_rise && nbr_ff && win;
  endsequence
  sequence s_wc_taken;
    tp1_rise && mac_ff && cfg.three && mstate_ff == CYC_WC;
  endsequence
  sequence s_block_end;
    tp1_rise && mac_ff && cur == CYC_XFER && cfg.three && last_ff;
  endsequence
  a_strobe_grab: assert property (
    strobe_rise && req_ff && cfg.enable |=>
      !BREAK_ACTIVE_LINE_N && !PROCESSOR_ADDRESS_DISABLE_N)
    else $error("strobe did not assert break lines");
  a_prio_window: assert property (
    DATA_BUS_OE != 12'h000 && !drive_word |->
      TIME_STATE_FOUR && DATA_BUS_OE == onehot)
    else $error("priority bit driven outside state four");
  a_win_lines: assert property (
    s_won |=> !BREAK_CYCLE_N && !STATE_INSTR_DISCONNECT_N
      && MEMORY_ADDRESS_LINES == $past(addr_sel))
    else $error("win did not assert cycle lines");
  a_lose_quiet: assert property (
    tp4_rise && nbr_ff && !win |=> BREAK_CYCLE_N)
    else $error("cycle taken despite higher priority");
  a_ma_timely: assert property (
    s_won |-> ##[1:MA_LAG] MEMORY_ADDRESS_OE)
    else $error("break address late");
  a_load_inhibit: assert property (
    tp1_rise && mac_ff |=> !ADDR_STATE_LOAD_INHIBIT_N
      && MEMORY_ADD_FLOP == ($past(cur_dir) == DIR_ADD))
    else $error("load inhibit or add flop wrong");
  a_path_out: assert property (
    tp1_rise && mac_ff && cur_dir == DIR_OUT |=>
      !MEMORY_DATA_DIRECTION_N && TRANSFER_PATH_SELECT_N)
    else $error("output path lines wrong");
  a_path_add: assert property (
    tp1_rise && mac_ff && cur_dir == DIR_ADD |=>
      MEMORY_DATA_DIRECTION_N && !TRANSFER_PATH_SELECT_N)
    else $error("add path lines wrong");
  a_release_order: assert property (
    $rose(ADDR_STATE_LOAD_INHIBIT_N) |->
      BREAK_CYCLE_N && BREAK_ACTIVE_LINE_N)
    else $error("lines released out of order");
  a_ts2_word: assert property (
    drive_word |-> DATA_BUS_OE == 12'hFFF && DATA_BUS_O == tx_ff)
    else $error("word not held in state two");
  a_rx_grab: assert property (
    tp3_rise && malc_ff && kind_ff == CYC_XFER && pout_ff |=>
      rx_ff == $past(MEMORY_DATA_LINES))
    else $error("output word not captured");
  a_ca_load: assert property (
    tp3_rise && malc_ff && kind_ff == CYC_CA |=>
      break_address_register_ff == $past(MEMORY_DATA_LINES))
    else $error("break address not loaded");
  a_three_step: assert property (
    s_wc_taken |=> mstate_ff == CYC_CA && kind_ff == CYC_WC)
    else $error("sequencer did not step");
  a_no_next: assert property (
    strobe_rise && !req_ff |=> BREAK_ACTIVE_LINE_N)
    else $error("break lines held without request");
  a_block_end: assert property (
    (s_block_end and !cfg.go) |=> !req_ff)
    else $error("request kept after block end");
endmodule : dbci_top

/* pkg/dbci_pkg.sv */
package dbci_pkg;
  // Word and bus widths
  localparam int DW = 12;
  localparam int AW = 8;
  localparam int NEV = 3;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MA_SETTLE_NS  = 50;
  localparam int MA_SETTLE_CYC =
    (MA_SETTLE_NS / CLK_PERIOD_NS) < 1 ? 1 : MA_SETTLE_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [AW-1:0] ADR_CTRL     = 8'h00;
  localparam logic [AW-1:0] ADR_ADDR     = 8'h04;
  localparam logic [AW-1:0] ADR_WDATA    = 8'h08;
  localparam logic [AW-1:0] ADR_RDATA    = 8'h0C;
  localparam logic [AW-1:0] ADR_STATUS   = 8'h10;
  localparam logic [AW-1:0] ADR_IRQ_STAT = 8'h14;
  localparam logic [AW-1:0] ADR_IRQ_CLR  = 8'h18;
  localparam logic [AW-1:0] ADR_IRQ_EN   = 8'h1C;

  // Control field positions
  localparam int CTRL_GO    = 0;
  localparam int CTRL_THREE = 1;
  localparam int CTRL_DIR   = 2;
  localparam int CTRL_PRIO  = 4;
  localparam int CTRL_EN    = 8;

  // Event bit positions
  localparam int EV_WORD  = 0;
  localparam int EV_BLOCK = 1;
  localparam int EV_OVF   = 2;

  // Reset values
  localparam logic [8:0]     CTRL_RST   = 9'h000;
  localparam logic [DW-1:0]  ADDR_RST   = 12'h000;
  localparam logic [DW-1:0]  WDATA_RST  = 12'h000;
  localparam logic [NEV-1:0] IRQ_EN_RST = 3'h0;

  // Increment word used by count and address cycles
  localparam logic [DW-1:0] INC_WORD = 12'h001;

  typedef enum logic [1:0] {DIR_IN, DIR_OUT, DIR_ADD} dbci_dir_t;
  typedef enum logic [1:0] {CYC_WC, CYC_CA, CYC_XFER} dbci_cyc_t;

  typedef struct packed {
    logic          cyc;
    logic          stb;
    logic          we;
    logic [AW-1:0] adr;
    logic [3:0]    sel;
    logic [31:0]   dat;
  } dbci_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dbci_wb_rsp_t;

  typedef struct packed {
    logic          go;
    logic          enable;
    logic          three;
    dbci_dir_t     dir;
    logic [3:0]    prio;
    logic [DW-1:0] addr;
    logic [DW-1:0] wdata;
  } dbci_cfg_t;

  typedef struct packed {
    logic           req;
    logic           busy;
    dbci_cyc_t      cyc;
    logic           last;
    logic           ovf;
    logic [DW-1:0]  rx;
    logic [NEV-1:0] ev;
  } dbci_sts_t;
endpackage : dbci_pkg

/* test/dbci_cpu_model.sv */
`timescale 1ns/100ps
// Processor timing and memory seen across the break pins
module dbci_cpu_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Pull-downs of a higher priority rival
  input  wire logic [11:0] rival,
  // Timing outputs
  output logic             ts2,
  output logic             ts4,
  output logic             p1,
  output logic             p3,
  output logic             p4,
  output logic             stb,
  // Memory and data bus
  input  wire logic [11:0] ma,
  input  wire logic        ma_oe,
  input  wire logic        dir_n,
  input  wire logic        path_n,
  input  wire logic [11:0] bus_o,
  input  wire logic [11:0] bus_oe,
  output logic      [11:0] bus,
  output logic      [11:0] md,
  output logic             ovf_n
);
  logic [4:0]  cnt_ff;
  logic        act_ff;
  logic        ovf_ff;
  logic [11:0] adr_ff;
  logic [12:0] sum;
  logic [11:0] mem [0:4095];
  // Twenty-clock memory cycle
  assign p1  = cnt_ff == 5'h00;
  assign ts2 = cnt_ff inside {[5'h01:5'h06]};
  assign p3  = cnt_ff == 5'h09;
  assign stb = p3;
  assign ts4 = cnt_ff >= 5'h0C;
  assign p4  = cnt_ff == 5'h10;
  // Pulled-up bus; the rival grounds its bits only in time state four
  assign bus = ~((bus_oe & ~bus_o) | (ts4 ? rival : 12'h000));
  // Junk outside the word so a stale value never passes
  assign md = act_ff ? mem[adr_ff] : {3{~cnt_ff[3:0]}};
  assign ovf_n = ~(act_ff & ovf_ff & (cnt_ff inside {[5'h07:5'h0B]}));
  // Memory written at the end of time state two
  always @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 5'h00;
      act_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == 5'h13) ? 5'h00 : cnt_ff + 5'h01;
      if (p1) act_ff <= 1'b0;
      if (cnt_ff == 5'h06 && ma_oe) begin
        act_ff <= 1'b1;
        adr_ff <= ma;
        sum = {1'b0, mem[ma]} + {1'b0, bus};
        ovf_ff <= !path_n && sum[12];
        if (dir_n) mem[ma] <= path_n ? bus : sum[11:0];
      end
    end
  end
endmodule : dbci_cpu_model

/* test/tb_dbci_top.sv */
`timescale 1ns/100ps
module tb_dbci_top;
  import dbci_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  dbci_wb_req_t wb_req = '0;
  dbci_wb_rsp_t wb_rsp;
  logic         irq, ts2, ts4, p1, p3, p4, stb, ovf_n, ma_oe;
  logic         bk_n, pa_n, cyc_n, sid_n, inh_n, path_n, dir_n, add;
  logic [11:0]  rival = 12'h000;
  logic [11:0]  ma, md, bus, bo, boe;
  logic [31:0]  rd;
  int           fails = 0;
  int           check_count = 0;
  int           tick = 0;
  always #50 clk = ~clk;
  dbci_top dbci_top_inst (.REF_CLK(clk), .SYS_RST(rst), .WB_REQ(wb_req),
    .WB_RSP(wb_rsp), .IRQ(irq), .TIME_STATE_TWO(ts2),
    .TIME_STATE_FOUR(ts4), .PULSE_ONE(p1), .PULSE_THREE(p3),
    .PULSE_FOUR(p4), .SAMPLE_STROBE(stb), .MEMORY_DATA_LINES(md),
    .OVERFLOW_N(ovf_n), .MEMORY_ADDRESS_LINES(ma),
    .MEMORY_ADDRESS_OE(ma_oe), .DATA_BUS_I(bus), .DATA_BUS_O(bo),
    .DATA_BUS_OE(boe), .BREAK_ACTIVE_LINE_N(bk_n),
    .PROCESSOR_ADDRESS_DISABLE_N(pa_n), .BREAK_CYCLE_N(cyc_n),
    .STATE_INSTR_DISCONNECT_N(sid_n), .ADDR_STATE_LOAD_INHIBIT_N(inh_n),
    .TRANSFER_PATH_SELECT_N(path_n), .MEMORY_DATA_DIRECTION_N(dir_n),
    .MEMORY_ADD_FLOP(add));
  dbci_cpu_model dbci_cpu_model_inst (.clk(clk), .rst(rst), .rival(rival),
    .ts2(ts2), .ts4(ts4), .p1(p1), .p3(p3), .p4(p4), .stb(stb), .ma(ma),
    .ma_oe(ma_oe), .dir_n(dir_n), .path_n(path_n), .bus_o(bo),
    .bus_oe(boe), .bus(bus), .md(md), .ovf_n(ovf_n));
  task automatic results;
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One classic cycle; ack and read data taken at the same rising edge
  task automatic bus_cyc(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do @(posedge clk); while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask : bus_cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_cyc(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
    bus_cyc(1'b0, a, 32'h0);
    chk(n, rd & m, e);
  endtask : rdchk
  // Poll the sticky events; the run timeout bounds it
  task automatic wait_ev(input int b);
    do bus_cyc(1'b0, ADR_IRQ_STAT, 32'h0); while (rd[b] !== 1'b1);
  endtask : wait_ev
  task automatic go(input logic [11:0] a, input logic [31:0] c);
    wr(ADR_IRQ_CLR, 32'h7);
    wr(ADR_ADDR, {20'h0, a});
    wr(ADR_CTRL, c);
  endtask : go
  function automatic logic [31:0] ctl(logic t, logic [1:0] d,
                                      logic [3:0] p);
    return {23'h0, 1'b1, p, d, t, 1'b1};
  endfunction : ctl
  // Watchdog and pin-level invariants
  always @(negedge clk) begin
    tick++;
    if (tick > 20000) begin
      fails++;
      results;
    end
    if (|boe) chk("drive_window", ts2 | ts4, 1'b1);
    if (!dir_n) chk("out_path", {path_n, add}, 2'b10);
    if (add) chk("add_path", {dir_n, path_n}, 2'b10);
    chk("disconnect", sid_n, cyc_n);
    chk("addr_disable", pa_n, bk_n);
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("idle", {bk_n, pa_n, cyc_n, sid_n, inh_n, irq}, 6'h3E);
    @(posedge clk);
    rdchk("ctrl_rst", ADR_CTRL, 32'hFFFFFFFF, 32'h0);
    rdchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    wr(ADR_IRQ_EN, 32'h7);
    // Input word, then interrupt mask and clear
    wr(ADR_WDATA, 32'hABC);
    go(12'h010, ctl(1'b0, DIR_IN, 4'h2));
    wait_ev(EV_WORD);
    chk("mem_in", dbci_cpu_model_inst.mem[16], 12'hABC);
    @(negedge clk);
    chk("irq_on", irq, 1'b1);
    @(posedge clk);
    wr(ADR_IRQ_EN, 32'h0);
    @(negedge clk);
    chk("irq_mask", irq, 1'b0);
    @(posedge clk);
    wr(ADR_IRQ_EN, 32'h7);
    wr(ADR_IRQ_CLR, 32'h7);
    rdchk("irq_clr", ADR_IRQ_STAT, 32'h7, 32'h0);
    // Higher device holds bit 0: wait, then win once it lets go
    rival <= 12'h001;
    wr(ADR_WDATA, 32'h5A5);
    go(12'h011, ctl(1'b0, DIR_IN, 4'h2));
    repeat (60) @(posedge clk);
    @(negedge clk);
    chk("lost", {bk_n, pa_n, cyc_n, sid_n}, 4'h3);
    @(posedge clk);
    rival <= 12'h000;
    wait_ev(EV_WORD);
    chk("mem_win", dbci_cpu_model_inst.mem[17], 12'h5A5);
    // Output word
    dbci_cpu_model_inst.mem[32] = 12'h36C;
    go(12'h020, ctl(1'b0, DIR_OUT, 4'h5));
    wait_ev(EV_WORD);
    rdchk("out_word", ADR_RDATA, 32'hFFF, 32'h36C);
    // Add with carry out
    dbci_cpu_model_inst.mem[48] = 12'hFFF;
    wr(ADR_WDATA, 32'h001);
    go(12'h030, ctl(1'b0, DIR_ADD, 4'hB));
    wait_ev(EV_WORD);
    chk("mem_add", dbci_cpu_model_inst.mem[48], 12'h000);
    rdchk("ovf_sts", ADR_STATUS, 32'h20, 32'h20);
    rdchk("ovf_ev", ADR_IRQ_STAT, 32'h4, 32'h4);
    // Two-word three-cycle block ending on count overflow
    dbci_cpu_model_inst.mem[64] = 12'hFFE;
    dbci_cpu_model_inst.mem[65] = 12'h07F;
    wr(ADR_WDATA, 32'h123);
    go(12'h040, ctl(1'b1, DIR_IN, 4'h0));
    wait_ev(EV_BLOCK);
    chk("count", dbci_cpu_model_inst.mem[64], 12'h000);
    chk("cur_adr", dbci_cpu_model_inst.mem[65], 12'h081);
    chk("word1", dbci_cpu_model_inst.mem[128], 12'h123);
    chk("word2", dbci_cpu_model_inst.mem[129], 12'h123);
    rdchk("req_drop", ADR_STATUS, 32'h1, 32'h0);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk("released", {bk_n, cyc_n, inh_n, ma_oe}, 4'hE);
    results;
  end
endmodule : tb_dbci_top
